//--- hdl/rotate_right_no_carry_exec.sv
// Execution of the rotate-right-without-carry instruction over four phases.
// Assumes a decoder that presents the instruction word at Q1 of each cycle
// and a register file answering a read address combinationally.
//
// Notes on behaviour
// - Match word top nibble 0010, next bits 000d; low byte is address.
// - Rotate operand right one place; bit 0 goes to bit 7, no carry.
// - Destination 0 writes working register; 1 writes back to file register.
// - No status flag is touched by this operation.
// - One instruction cycle: decode Q1, read Q2, compute Q3, write Q4.
`timescale 1ns/1ps
`default_nettype none
`include "rotate_defines.svh"

module rotate_right_no_carry_exec (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic instr_valid,
    input wire logic [15:0] instr_word,
    input wire logic [7:0] file_rdata,
    output logic [7:0] file_addr,
    output logic file_we,
    output logic [7:0] file_wdata,
    output logic [7:0] working_register,
    output logic op_busy,
    output logic op_done
);

    // ------------------------------------------------------------------------
    // Phase sequencer
    // ------------------------------------------------------------------------
    rotate_pkg::phase_t phase_q;
    logic active_q;
    logic dest_q;
    logic [7:0] addr_q;
    logic [7:0] operand_q;
    logic [7:0] result_q;
    logic [7:0] rot_result;
    logic rotate_right_nocarry_op;
    logic done_q;

    // Decode of the instruction word.
    assign rotate_right_nocarry_op = instr_valid &&
        (instr_word[`OPC_HI_MSB:`OPC_HI_LSB] == `OPC_HI_VAL) &&
        (instr_word[`OPC_MID_MSB:`OPC_MID_LSB] == `OPC_MID_VAL);

    // Phase advances each clock; a new word is taken only at Q1.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_q <= rotate_pkg::PH_Q1;
        end else begin
            case (phase_q)
                rotate_pkg::PH_Q1: phase_q <= rotate_pkg::PH_Q2;
                rotate_pkg::PH_Q2: phase_q <= rotate_pkg::PH_Q3;
                rotate_pkg::PH_Q3: phase_q <= rotate_pkg::PH_Q4;
                rotate_pkg::PH_Q4: phase_q <= rotate_pkg::PH_Q1;
                default: phase_q <= rotate_pkg::PH_Q1;
            endcase
        end
    end

    // Latch the decoded fields at Q1; the operation is active to Q4.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            active_q <= 1'b0;
            dest_q <= 1'b0;
            addr_q <= 8'h00;
        end else if (phase_q == rotate_pkg::PH_Q1) begin
            active_q <= rotate_right_nocarry_op;
            dest_q <= instr_word[`DEST_BIT];
            addr_q <= instr_word[`ADDR_MSB:`ADDR_LSB];
        end else if (phase_q == rotate_pkg::PH_Q4) begin
            active_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Datapath: read in Q2, compute in Q3
    // ------------------------------------------------------------------------
    assign file_addr = addr_q;

    rotate_unit u_rotate (
        .operand(operand_q),
        .result(rot_result)
    );

    // Operand is captured at the end of Q2, result at the end of Q3.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            operand_q <= 8'h00;
            result_q <= 8'h00;
        end else begin
            if (active_q && phase_q == rotate_pkg::PH_Q2) begin
                operand_q <= file_rdata;
            end
            if (active_q && phase_q == rotate_pkg::PH_Q3) begin
                result_q <= rot_result;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Write-back in Q4
    // ------------------------------------------------------------------------
    // File write strobe is high through Q4 only when the destination is 1.
    assign file_we = active_q && dest_q &&
        (phase_q == rotate_pkg::PH_Q4);
    assign file_wdata = result_q;

    // Working register updates at the end of Q4 when the destination is 0.
    // No flag state exists here, so flags are never disturbed.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            working_register <= `WORKING_REG_RESET;
        end else if (active_q && !dest_q &&
                     phase_q == rotate_pkg::PH_Q4) begin
            working_register <= result_q;
        end
    end

    // Completion pulse, one clock after the Q4 edge.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            done_q <= 1'b0;
        end else begin
            done_q <= active_q && (phase_q == rotate_pkg::PH_Q4);
        end
    end

    assign op_busy = active_q;
    assign op_done = done_q;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_decode_match: assert property (
        phase_q == rotate_pkg::PH_Q1 && instr_valid &&
        instr_word[15:9] == 7'h10 |=> active_q)
        else $error("Matching word not accepted.");

    a_decode_reject: assert property (
        phase_q == rotate_pkg::PH_Q1 && instr_word[15:9] != 7'h10
        |=> !active_q)
        else $error("Non-matching word accepted.");

    a_rotate_value: assert property (
        active_q && phase_q == rotate_pkg::PH_Q3 |=>
        result_q == {$past(operand_q[0]), $past(operand_q[7:1])})
        else $error("Rotation result wrong.");

    a_file_write: assert property (
        phase_q == rotate_pkg::PH_Q1 && rotate_right_nocarry_op &&
        instr_word[8] |=> ##2 file_we && file_addr == $past(instr_word[7:0], 3))
        else $error("File write-back missing.");

    a_working_register_hold: assert property (
        dest_q || !active_q |=> $stable(working_register))
        else $error("Working register changed wrongly.");

    a_no_write_d0: assert property (
        active_q && !dest_q |-> !file_we)
        else $error("File written with destination zero.");

    a_one_cycle: assert property (
        phase_q == rotate_pkg::PH_Q1 && rotate_right_nocarry_op |=>
        active_q [*3] ##1 op_done)
        else $error("Operation did not finish in one cycle.");

    a_we_only_q4: assert property (
        file_we |-> phase_q == rotate_pkg::PH_Q4)
        else $error("File write outside Q4.");

    // The checks below tie each phase to the value it must hand on.
    // A slip of one phase in capture or write-back would show here
    // before it shows as a wrong result at the pins.
    a_working_register_update: assert property (
        active_q && !dest_q && phase_q == rotate_pkg::PH_Q4 |=>
        working_register == $past(result_q))
        else $error("Working register not written.");

    a_operand_read: assert property (
        active_q && phase_q == rotate_pkg::PH_Q2 |=>
        operand_q == $past(file_rdata))
        else $error("Operand not read from the file.");

    a_addr_hold: assert property (
        phase_q != rotate_pkg::PH_Q1 |=> $stable(file_addr))
        else $error("File address moved inside a cycle.");

    a_wdata_rotated: assert property (
        file_we |-> file_wdata == {operand_q[0], operand_q[7:1]})
        else $error("Write data is not the rotated operand.");

    a_done_idle: assert property (
        op_done |-> !op_busy)
        else $error("Busy still high at completion.");

    // Covers for the main scenarios: file write-back, working register
    // write-back, a wrapping bit, and two operations back to back.
    c_write_file: cover property (file_we);
    c_back_to_back: cover property (op_done ##1 op_busy);
    c_write_working_register: cover property (active_q && !dest_q ##3 op_done);
    c_wrap_bit: cover property (active_q && operand_q[0] &&
        phase_q == rotate_pkg::PH_Q3);

endmodule : rotate_right_no_carry_exec

`default_nettype wire

//--- common/rotate_defines.svh
// Constants for the rotate-right-without-carry execution block.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef ROTATE_DEFINES_SVH
`define ROTATE_DEFINES_SVH

// -----------------------------------------------------------------------------
// Instruction word fields
// -----------------------------------------------------------------------------
`define OPC_HI_MSB 15
`define OPC_HI_LSB 12
`define OPC_HI_VAL 4'h2
`define OPC_MID_MSB 11
`define OPC_MID_LSB 9
`define OPC_MID_VAL 3'h0
`define DEST_BIT 8
`define ADDR_MSB 7
`define ADDR_LSB 0

// -----------------------------------------------------------------------------
// Reset values and phase timing
// -----------------------------------------------------------------------------
`define WORKING_REG_RESET 8'h00
`define PHASES_PER_CYCLE 4

`endif

//--- common/rotate_pkg.sv
// Types shared by the rotate execution block.
// Assumes nothing beyond a SystemVerilog compiler.
package rotate_pkg;

    // -------------------------------------------------------------------------
    // Quarter phases of one instruction cycle
    // -------------------------------------------------------------------------
    typedef enum logic [1:0] {
        PH_Q1 = 2'b00,
        PH_Q2 = 2'b01,
        PH_Q3 = 2'b10,
        PH_Q4 = 2'b11
    } phase_t;

endpackage : rotate_pkg

//--- hdl/rotate_unit.sv
// Combinational one-place right rotation of an 8-bit operand.
// Assumes a caller that registers the result.
`timescale 1ns/1ps
`default_nettype none

module rotate_unit (
    input wire logic [7:0] operand,
    output logic [7:0] result
);

    // ------------------------------------------------------------------------
    // Rotation
    // ------------------------------------------------------------------------
    // Bit 0 wraps to bit 7; no carry enters or leaves.
    assign result = {operand[0], operand[7:1]};

endmodule : rotate_unit

`default_nettype wire

//--- verification/file_model.sv
// Behavioural data register file facing the rotate block.
// Assumes one clock; reads are combinational, writes land on the edge.
`timescale 1ns/1ps
`default_nettype none

module file_model (
    input wire logic clk,
    input wire logic [7:0] addr,
    input wire logic we,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata
);
    logic [7:0] mem [256];

    // Contents start as a fixed pattern that the bench mirrors.
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = 8'(i * 37 + 5);
    end

    // Any of the 256 places is read at once and written on the edge.
    assign rdata = mem[addr];
    always @(posedge clk) begin
        if (we) mem[addr] <= wdata;
    end
endmodule : file_model
`default_nettype wire

//--- verification/testbench.sv
// Self-checking bench for the rotate execution block.
// Assumes the file_model partner and a 40 ns clock.
`timescale 1ns/1ps
`default_nettype none

module testbench;
    typedef struct {
        logic d;
        logic [7:0] a;
        logic [7:0] old;
        logic [7:0] res;
    } note_t;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic instr_valid = 1'b0;
    logic [15:0] instr_word = 16'h0000;
    logic [7:0] file_rdata, file_addr, file_wdata, working_register;
    logic file_we, op_busy, op_done;
    logic [7:0] exp_mem [256];
    logic [7:0] exp_w = 8'h00;
    note_t notes[$];
    note_t n;
    int num_errors = 0;
    int n_compared = 0;

    rotate_right_no_carry_exec rotate_right_no_carry_exec_i (
        .clk(clk), .rst_n(rst_n), .instr_valid(instr_valid),
        .instr_word(instr_word), .file_rdata(file_rdata),
        .file_addr(file_addr), .file_we(file_we), .file_wdata(file_wdata),
        .working_register(working_register), .op_busy(op_busy),
        .op_done(op_done));
    file_model file_model_i (.clk(clk), .addr(file_addr), .we(file_we),
        .wdata(file_wdata), .rdata(file_rdata));

    // Clock at 25 MHz.
    initial forever #20 clk = ~clk;

    // Counts one comparison and reports a mismatch.
    task automatic check(input logic ok, input string msg);
        n_compared++;
        if (!ok) begin
            num_errors++;
            $display("FAIL %0t %s", $time, msg);
        end
    endtask : check

    // Presents one word for a whole cycle and notes what it must do.
    task automatic issue(input logic v, input logic [15:0] w);
        note_t t;
        instr_valid = v;
        instr_word = w;
        if (v && w[15:9] == 7'h10) begin
            t.d = w[8];
            t.a = w[7:0];
            t.old = exp_mem[t.a];
            t.res = {t.old[0], t.old[7:1]};
            if (t.d) exp_mem[t.a] = t.res;
            notes.push_back(t);
        end
        repeat (4) @(posedge clk);
        #1;
    endtask : issue

    // Prints the counts and the verdict, then stops.
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : conclude

    // -------------------------------------------------------------------
    // Result watcher: takes the oldest note whenever a result shows.
    // -------------------------------------------------------------------
    always @(negedge clk) begin
        if (file_we) begin
            check(notes.size() > 0 && notes[0].d === 1'b1, "stray write");
            check(file_addr === notes[0].a, "write address");
            check(file_wdata === notes[0].res, "write data");
            check(op_busy === 1'b1, "idle during write");
        end
        if (op_busy !== 1'b0 && notes.size() == 0) begin
            check(1'b0, "busy without op");
        end
        if (op_done === 1'b1 && notes.size() == 0) begin
            check(1'b0, "done without op");
        end else if (op_done === 1'b1) begin
            n = notes.pop_front();
            if (!n.d) exp_w = n.res;
            check(working_register === exp_w, "working value");
            check(op_busy === 1'b0, "busy at done");
            check(file_model_i.mem[n.a] === (n.d ? n.res : n.old), "file");
        end
    end

    // Stops a hung run.
    initial begin
        #(40 * 600);
        num_errors++;
        conclude();
    end

    // -------------------------------------------------------------------
    // Test sequence.
    // -------------------------------------------------------------------
    initial begin
        for (int i = 0; i < 256; i++) exp_mem[i] = 8'(i * 37 + 5);
        void'($urandom(55085));
        repeat (4) @(posedge clk);
        #1 rst_n = 1'b1;
        // Address ends, both destinations, back to back on one place.
        issue(1'b1, 16'h20FF);
        issue(1'b1, 16'h21FF);
        issue(1'b1, 16'h2100);
        issue(1'b1, 16'h2000);
        $display("test directed done");
        for (int i = 0; i < 40; i++) begin
            issue(1'($urandom), ($urandom % 3 == 0) ? 16'($urandom)
                : {7'h10, 9'($urandom)});
        end
        $display("test random done");
        issue(1'b0, 16'h2155);
        issue(1'b1, 16'h2355);
        repeat (8) @(posedge clk);
        check(notes.size() == 0, "ops left over");
        $display("test refusals done");
        conclude();
    end
endmodule : testbench
`default_nettype wire
